// file: src/dlw_pkg.sv
package dlw_pkg;

    // ------------------------------------------------------------
    // Pin map
    // ------------------------------------------------------------
    localparam int NDIO       = 96;
    localparam int POS_TRIG   = 96;
    localparam int POS_LBL    = 104;
    localparam int POS_LBR    = 112;
    localparam int POS_STAR   = 120;
    localparam int NPIN       = 121;
    localparam int NWORD      = 4;
    localparam int WORD_W     = 32;
    localparam int GRP_W      = 8;
    localparam int SEL_W      = 7;
    localparam int CONN0_BASE = 0;
    localparam int CONN1_BASE = 16;
    localparam int CONN2_BASE = 56;
    localparam int CONN0_GRPS = 2;
    localparam int CONNX_GRPS = 5;

    // ------------------------------------------------------------
    // Clock and reference
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int REF_MHZ = 10;
    localparam int REF_DIV = CLK_MHZ / REF_MHZ;
    localparam int CNT_W   = 6;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_WCTRL = 8'h00;
    localparam logic [7:0] A_WTMO  = 8'h04;
    localparam logic [7:0] A_LINE  = 8'h08;
    localparam logic [7:0] A_GRP   = 8'h0C;
    localparam logic [7:0] A_STAT  = 8'h10;
    localparam logic [3:0] R_DOUT  = 4'h4;
    localparam logic [3:0] R_DOE   = 4'h5;
    localparam logic [3:0] R_ARB   = 4'h6;
    localparam logic [3:0] R_DIN   = 4'h7;

    localparam int F_START = 0;
    localparam int F_MODE  = 1;
    localparam int F_SEL   = 8;
    localparam int F_BUSY  = 16;
    localparam int F_DONE  = 17;
    localparam int F_HIT   = 18;
    localparam int F_LDAT  = 8;
    localparam int F_LEN   = 9;
    localparam int F_GIDX  = 0;
    localparam int F_GCON  = 4;
    localparam int F_GDAT  = 8;
    localparam int F_GEN   = 16;
    localparam int F_SLOT2 = 0;
    localparam int F_LOCK  = 1;

    typedef enum logic [2:0] {
        DLW_ANY,
        DLW_FALL,
        DLW_RISE,
        DLW_HIGH,
        DLW_LOW
    } dlw_mode_e;

endpackage: dlw_pkg

// file: src/dlw_wait_if.sv
`timescale 1ns/1ps
interface dlw_wait_if;
    import dlw_pkg::*;
    logic               start;
    dlw_mode_e          mode;
    logic signed [31:0] tmo;
    logic               sample;
    logic               busy;
    logic               done;
    logic               timed_out;
    modport eng (input start, mode, tmo, sample,
                 output busy, done, timed_out);
    modport ctl (output start, mode, tmo, sample,
                 input busy, done, timed_out);
endinterface: dlw_wait_if

// file: src/dlw_sync.sv
`timescale 1ns/1ps
module dlw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dlw_sync_s;

    dlw_sync_s st_ff;
    dlw_sync_s nxt_st;

    always_comb begin
        nxt_st.s1 = d_i;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.s2;
endmodule: dlw_sync

// file: src/dlw_wait.sv
`timescale 1ns/1ps
module dlw_wait (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Wait request
    dlw_wait_if.eng  wi
);
    import dlw_pkg::*;

    typedef enum logic [0:0] {
        W_IDLE,
        W_RUN
    } dlw_wst_e;

    typedef struct packed {
        dlw_wst_e           st;
        dlw_mode_e          mode;
        logic signed [31:0] cnt;
        logic               prev;
        logic               busy;
        logic               done;
        logic               hit;
    } dlw_wait_s;

    dlw_wait_s st_ff;
    dlw_wait_s nxt_st;
    logic      met;

    function automatic logic cond_met(input dlw_mode_e m,
                                      input logic p,
                                      input logic s);
        case (m)
            DLW_ANY:  return p != s;
            DLW_FALL: return p && !s;
            DLW_RISE: return !p && s;
            DLW_HIGH: return s;
            DLW_LOW:  return !s;
            default:  return 1'b0;
        endcase
    endfunction: cond_met

    // Edges compare the previous sample with the current one.
    assign met = cond_met(st_ff.mode, st_ff.prev, wi.sample);

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.prev = wi.sample;
        case (st_ff.st)
            W_IDLE: begin
                if (wi.start) begin
                    nxt_st.mode = wi.mode;
                    nxt_st.cnt  = wi.tmo;
                    if (wi.tmo == 32'sh0000_0000) begin
                        nxt_st.done = 1'b1;
                        nxt_st.hit  = 1'b1;
                    end else begin
                        nxt_st.busy = 1'b1;
                        nxt_st.hit  = 1'b0;
                        nxt_st.st   = W_RUN;
                    end
                end
            end
            W_RUN: begin
                if (met) begin
                    nxt_st.done = 1'b1;
                    nxt_st.busy = 1'b0;
                    nxt_st.st   = W_IDLE;
                end else if (st_ff.cnt == 32'sh0000_0001) begin
                    nxt_st.done = 1'b1;
                    nxt_st.hit  = 1'b1;
                    nxt_st.busy = 1'b0;
                    nxt_st.st   = W_IDLE;
                end else if (st_ff.cnt > 32'sh0000_0000) begin
                    // A negative count is never decremented.
                    nxt_st.cnt = st_ff.cnt - 32'sh0000_0001;
                end
            end
            default: begin
                nxt_st = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wi.busy      = st_ff.busy;
    assign wi.done      = st_ff.done;
    assign wi.timed_out = st_ff.hit;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    zero_tmo_a: assert property (
        wi.start && !wi.busy && wi.tmo == 0 |=> wi.done && wi.timed_out
    ) else $error("zero timeout did not end at once");
    neg_hold_a: assert property (
        st_ff.st == W_RUN && st_ff.cnt < 0 && !met |=> wi.busy
    ) else $error("negative timeout ended a wait");
    pos_end_a: assert property (
        st_ff.st == W_RUN && st_ff.cnt == 1 && !met
        |=> wi.done && wi.timed_out && !wi.busy
    ) else $error("positive timeout not honoured");
    any_edge_a: assert property (
        wi.busy && st_ff.mode == DLW_ANY && $changed(wi.sample)
        |=> wi.done && !wi.timed_out
    ) else $error("any edge missed");
    fall_edge_a: assert property (
        wi.busy && st_ff.mode == DLW_FALL && $fell(wi.sample)
        |=> wi.done && !wi.timed_out
    ) else $error("falling edge missed");
    rise_edge_a: assert property (
        wi.busy && st_ff.mode == DLW_RISE && $rose(wi.sample)
        |=> wi.done && !wi.timed_out
    ) else $error("rising edge missed");
    high_lvl_a: assert property (
        wi.busy && st_ff.mode == DLW_HIGH && wi.sample
        |=> wi.done && !wi.timed_out
    ) else $error("high level missed");
    low_lvl_a: assert property (
        wi.busy && st_ff.mode == DLW_LOW && !wi.sample
        |=> wi.done && !wi.timed_out
    ) else $error("low level missed");
    done_pulse_a: assert property (
        wi.done |=> !wi.done ##1 !wi.done
    ) else $error("done is not a single pulse");

    met_c:  cover property (wi.done && !wi.timed_out);
    tmo_c:  cover property (wi.busy ##1 wi.done && wi.timed_out);
endmodule: dlw_wait

// file: src/dlw_top.sv
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Summary of operation
// - A byte group moves eight lines together.
// - Group n covers lines base+8n..base+8n+7 of its connector (base 0, 16 or 56), LSB first.
// - Every line has separate data and enable.
// - Per-line setting picks the driving accessor.
// - Wait timeout counts module clock cycles.
// - Zero timeout ends the wait at once.
// - Negative timeout never expires.
// - Positive timeout ends after that many cycles.
// - Any-edge wait ends on either transition.
// - Falling-edge wait ends on high-to-low.
// - Rising-edge wait ends on low-to-high.
// - High-level wait ends once input is high.
// - Low-level wait ends once input is low.
// - Lock flag shows the reference period matches; the clock is left unchanged.
// - In slot two, left lines become star triggers.
// - Lines update every cycle, digital only.
module dlw_top (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       resetn_i,
    // APB slave
    input  wire logic [7:0]                 paddr_i,
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // Lines, triggers and local bus pins
    input  wire logic [dlw_pkg::NPIN-1:0]   pin_in_i,
    output logic      [dlw_pkg::NPIN-1:0]   pin_out_o,
    output logic      [dlw_pkg::NPIN-1:0]   pin_oe_o,
    // Chassis
    input  wire logic                       ref_clk10_i,
    input  wire logic                       slot2_i,
    output logic                            ref_locked_o,
    // User logic accessor
    input  wire logic [dlw_pkg::NPIN-1:0]   usr_dout_i,
    input  wire logic [dlw_pkg::NPIN-1:0]   usr_doe_i,
    output logic      [dlw_pkg::NPIN-1:0]   usr_din_o
);
    import dlw_pkg::*;

    typedef struct packed {
        logic [NPIN-1:0]  dout;
        logic [NPIN-1:0]  doe;
        logic [NPIN-1:0]  arb;
        logic [NPIN-1:0]  din;
        logic [NPIN-1:0]  pout;
        logic [NPIN-1:0]  poe;
        logic [31:0]      rdata;
        logic             rdy;
        logic             err;
        logic             start;
        dlw_mode_e        mode;
        logic [SEL_W-1:0] sel;
        logic [31:0]      tmo;
        logic             wdone;
        logic             whit;
        logic             slot2;
        logic             refq;
        logic [CNT_W-1:0] refcnt;
        logic             locked;
    } dlw_top_s;

    dlw_top_s         st_ff;
    dlw_top_s         nxt_st;
    logic [NPIN+1:0]  sync_q;
    logic [NPIN-1:0]  pin_s;
    logic             ref_s;
    logic             slot2_s;
    logic [NPIN-1:0]  src_d;
    logic [NPIN-1:0]  src_e;
    logic [SEL_W:0]   gb;
    logic [GRP_W-1:0] gdat;
    logic             setup;
    logic             access;

    dlw_wait_if wi ();

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pins, strap and reference share one two-stage synchroniser.
    dlw_sync #(
        .W (NPIN + 2)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      ({slot2_i, ref_clk10_i, pin_in_i}),
        .q_o      (sync_q)
    );

    assign pin_s   = sync_q[NPIN-1:0];
    assign ref_s   = sync_q[NPIN];
    assign slot2_s = sync_q[NPIN+1];

    dlw_wait u_wait (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .wi       (wi)
    );

    assign wi.start  = st_ff.start;
    assign wi.mode   = st_ff.mode;
    assign wi.tmo    = st_ff.tmo;
    assign wi.sample = st_ff.din[st_ff.sel];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] get_word(input logic [NPIN-1:0] v,
                                             input logic [1:0]      w);
        logic [NWORD*WORD_W-1:0] t;
        t           = '0;
        t[NPIN-1:0] = v;
        return t[w*WORD_W +: WORD_W];
    endfunction: get_word

    function automatic logic [NPIN-1:0] set_word(
        input logic [NPIN-1:0] v,
        input logic [1:0]      w,
        input logic [31:0]     d
    );
        logic [NWORD*WORD_W-1:0] t;
        t                      = '0;
        t[NPIN-1:0]            = v;
        t[w*WORD_W +: WORD_W]  = d;
        return t[NPIN-1:0];
    endfunction: set_word

    // Returns {valid, first line} of a group on a connector.
    function automatic logic [SEL_W:0] grp_base(input logic [1:0] c,
                                                input logic [2:0] g);
        logic [SEL_W:0] r;
        r = '0;
        case (c)
            2'h0: begin
                r[SEL_W]     = int'(g) < CONN0_GRPS;
                r[SEL_W-1:0] = SEL_W'(CONN0_BASE + GRP_W * int'(g));
            end
            2'h1: begin
                r[SEL_W]     = int'(g) < CONNX_GRPS;
                r[SEL_W-1:0] = SEL_W'(CONN1_BASE + GRP_W * int'(g));
            end
            2'h2: begin
                r[SEL_W]     = int'(g) < CONNX_GRPS;
                r[SEL_W-1:0] = SEL_W'(CONN2_BASE + GRP_W * int'(g));
            end
            default: begin
                r = '0;
            end
        endcase
        return r;
    endfunction: grp_base

    // ------------------------------------------------------------
    // Accessor arbitration
    // ------------------------------------------------------------
    // A set arbitration bit hands the line to the user port.
    assign src_d = (st_ff.arb & usr_dout_i) | (~st_ff.arb & st_ff.dout);
    assign src_e = (st_ff.arb & usr_doe_i) | (~st_ff.arb & st_ff.doe);

    assign gb     = grp_base(pwdata_i[F_GCON +: 2], pwdata_i[F_GIDX +: 3]);
    assign gdat   = pwdata_i[F_GDAT +: GRP_W];
    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i && st_ff.rdy;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [NPIN-1:0] smask;
        logic [1:0]      w;
        smask        = '0;
        w            = paddr_i[3:2];
        nxt_st       = st_ff;
        nxt_st.start = 1'b0;

        // The answer is prepared in setup so pready leaves a flop.
        if (setup) begin
            nxt_st.rdy   = 1'b1;
            nxt_st.err   = 1'b0;
            nxt_st.rdata = '0;
            case (paddr_i)
                A_WCTRL: begin
                    nxt_st.rdata[F_MODE +: 3]     = st_ff.mode;
                    nxt_st.rdata[F_SEL +: SEL_W]  = st_ff.sel;
                    nxt_st.rdata[F_BUSY]          = wi.busy;
                    nxt_st.rdata[F_DONE]          = st_ff.wdone;
                    nxt_st.rdata[F_HIT]           = st_ff.whit;
                end
                A_WTMO: begin
                    nxt_st.rdata = st_ff.tmo;
                end
                A_LINE, A_GRP: begin
                    nxt_st.rdata = '0;
                end
                A_STAT: begin
                    nxt_st.rdata[F_SLOT2] = st_ff.slot2;
                    nxt_st.rdata[F_LOCK]  = st_ff.locked;
                end
                default: begin
                    if (paddr_i[1:0] != 2'h0) begin
                        nxt_st.err = 1'b1;
                    end else begin
                        case (paddr_i[7:4])
                            R_DOUT:  nxt_st.rdata = get_word(st_ff.dout, w);
                            R_DOE:   nxt_st.rdata = get_word(st_ff.doe, w);
                            R_ARB:   nxt_st.rdata = get_word(st_ff.arb, w);
                            R_DIN:   nxt_st.rdata = get_word(st_ff.din, w);
                            default: nxt_st.err   = 1'b1;
                        endcase
                    end
                end
            endcase
        end

        if (access) begin
            nxt_st.rdy = 1'b0;
            nxt_st.err = 1'b0;
            if (pwrite_i && !st_ff.err) begin
                case (paddr_i)
                    A_WCTRL: begin
                        if (pwdata_i[F_START] && !wi.busy &&
                            int'(pwdata_i[F_SEL +: SEL_W]) < NPIN &&
                            pwdata_i[F_MODE +: 3] <= DLW_LOW) begin
                            nxt_st.start = 1'b1;
                            nxt_st.mode  = dlw_mode_e'(pwdata_i[F_MODE +: 3]);
                            nxt_st.sel   = pwdata_i[F_SEL +: SEL_W];
                            nxt_st.wdone = 1'b0;
                            nxt_st.whit  = 1'b0;
                        end
                    end
                    A_WTMO: begin
                        nxt_st.tmo = pwdata_i;
                    end
                    A_LINE: begin
                        if (int'(pwdata_i[SEL_W-1:0]) < NPIN) begin
                            nxt_st.dout[pwdata_i[SEL_W-1:0]] =
                                pwdata_i[F_LDAT];
                            nxt_st.doe[pwdata_i[SEL_W-1:0]] =
                                pwdata_i[F_LEN];
                        end
                    end
                    A_GRP: begin
                        // Last write wins between line and group.
                        if (gb[SEL_W]) begin
                            nxt_st.dout[gb[SEL_W-1:0] +: GRP_W] = gdat;
                            nxt_st.doe[gb[SEL_W-1:0] +: GRP_W] =
                                pwdata_i[F_GEN +: GRP_W];
                        end
                    end
                    A_STAT: begin
                        nxt_st.rdata = st_ff.rdata;
                    end
                    default: begin
                        case (paddr_i[7:4])
                            R_DOUT: nxt_st.dout =
                                set_word(st_ff.dout, w, pwdata_i);
                            R_DOE: nxt_st.doe =
                                set_word(st_ff.doe, w, pwdata_i);
                            R_ARB: nxt_st.arb =
                                set_word(st_ff.arb, w, pwdata_i);
                            default: nxt_st.rdata = st_ff.rdata;
                        endcase
                    end
                endcase
            end
        end

        // A finished wait latches its cause until the next start.
        if (wi.done) begin
            nxt_st.wdone = 1'b1;
            nxt_st.whit  = wi.timed_out;
        end

        // In slot two the star pin carries the chassis clock, so it
        // is never driven or read; the left bus lines stay live as
        // the star triggers.
        nxt_st.slot2 = slot2_s;
        if (st_ff.slot2) begin
            smask[POS_STAR] = 1'b1;
        end

        // Every line except the star pin in slot two is sampled and driven on every cycle.
        nxt_st.din  = pin_s & ~smask;
        nxt_st.pout = src_d;
        nxt_st.poe  = src_e & ~smask;

        // Lock is seen when the reference period is exactly REF_DIV
        // module cycles; the module clock itself never changes.
        nxt_st.refq = ref_s;
        if (ref_s && !st_ff.refq) begin
            nxt_st.locked = int'(st_ff.refcnt) == REF_DIV - 1;
            nxt_st.refcnt = '0;
        end else if (&st_ff.refcnt) begin
            nxt_st.locked = 1'b0;
        end else begin
            nxt_st.refcnt = st_ff.refcnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata_o     = st_ff.rdata;
    assign pready_o     = st_ff.rdy;
    assign pslverr_o    = st_ff.err;
    assign pin_out_o    = st_ff.pout;
    assign pin_oe_o     = st_ff.poe;
    assign usr_din_o    = st_ff.din;
    assign ref_locked_o = st_ff.locked;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    apb_answer_a: assert property (
        setup |=> pready_o ##1 !pready_o
    ) else $error("APB answer not in one cycle");
    arb_pick_a: assert property (
        1'b1 |=> pin_out_o == $past((st_ff.arb & usr_dout_i) |
            (~st_ff.arb & st_ff.dout))
    ) else $error("arbitration picked wrong source");
    grp_write_a: assert property (
        access && pwrite_i && !pslverr_o && paddr_i == A_GRP && gb[SEL_W]
        |=> st_ff.dout[$past(gb[SEL_W-1:0]) +: GRP_W] == $past(gdat)
    ) else $error("group write did not move eight lines");
    star_guard_a: assert property (
        st_ff.slot2 |=> !pin_oe_o[POS_STAR] && !usr_din_o[POS_STAR]
    ) else $error("star line used in slot two");

    grp_wr_c: cover property (access && pwrite_i && paddr_i == A_GRP);
    lock_c:   cover property ($rose(ref_locked_o));
endmodule: dlw_top

// file: bench/dlw_partner.sv
`timescale 1ns/1ps
module dlw_partner (
    // Pins seen from outside the module
    input  wire logic [dlw_pkg::NPIN-1:0] pin_out_i,
    input  wire logic [dlw_pkg::NPIN-1:0] pin_oe_i,
    input  wire logic [dlw_pkg::NPIN-1:0] ext_i,
    output logic      [dlw_pkg::NPIN-1:0] pin_in_o,
    // Chassis reference
    output logic                          ref_clk10_o
);
    import dlw_pkg::*;
    // A driven pin reads back its own level, a released one the far side.
    assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
    // Offset start keeps the reference unrelated in phase to the clock.
    initial begin
        ref_clk10_o = 1'b0;
        #1.3;
        forever #50 ref_clk10_o = ~ref_clk10_o;
    end
endmodule: dlw_partner

// file: bench/dlw_top_tb_top.sv
`timescale 1ns/1ps
module dlw_top_tb_top;
    import dlw_pkg::*;
    logic            clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0;
    logic            pwrite_i = 0, pready_o, pslverr_o, er, slot2_i = 0;
    logic            ref_clk10_i, ref_locked_o;
    logic [7:0]      paddr_i = 0;
    logic [31:0]     pwdata_i = 0, prdata_o, rd, d, d0;
    logic [NPIN-1:0] pin_in_i, pin_out_o, pin_oe_o, usr_din_o, ext = 0;
    logic [NPIN-1:0] usr_dout_i = 0, usr_doe_i = 0;
    int              errors = 0, n_checks = 0, seed = 32'had46e991;
    always #2.5 clk_i = ~clk_i;
    dlw_top dut_u (.clk_i, .resetn_i, .paddr_i, .psel_i, .penable_i,
        .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pin_in_i,
        .pin_out_o, .pin_oe_o, .ref_clk10_i, .slot2_i, .ref_locked_o,
        .usr_dout_i, .usr_doe_i, .usr_din_o);
    dlw_partner par_u (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
        .ext_i(ext), .pin_in_o(pin_in_i), .ref_clk10_o(ref_clk10_i));
    function automatic int gb(input int c, input int g);
        return (c == 0 ? CONN0_BASE : c == 1 ? CONN1_BASE : CONN2_BASE) + 8*g;
    endfunction: gb
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask: chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, wd};
        @(posedge clk_i) penable_i <= 1'b1;
        // Pready is taken at the rising edge at which it stands.
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++k < 40);
        if (k >= 40) begin
            errors++;
            $display("MISMATCH %0t pready never came", $time);
        end
        rd = prdata_o;
        er = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask: apb
    task automatic wt(input int m, input logic [31:0] t);
        apb(1, A_WTMO, t);
        apb(1, A_WCTRL, {17'h0, 7'd70, 4'h0, 3'(m), 1'b1});
    endtask: wt
    task automatic pl();
        int k;
        k = 0;
        do apb(0, A_WCTRL, 0); while (rd[F_DONE] !== 1'b1 && ++k < 60);
    endtask: pl
    task give_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask: give_verdict
    initial begin
        #100us;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        chk(pin_oe_o[31:0], 0);
        resetn_i <= 1'b1;
        apb(1, A_LINE, 32'h0000_0305);
        repeat (3) @(posedge clk_i);
        chk(32'({pin_out_o[5], pin_oe_o[5]}), 3);
        for (int g = 0; g < CONNX_GRPS; g++) begin
            d = $random(seed);
            if (g == 0) d0 = d;
            apb(1, A_GRP, {8'h00, 8'hFF, d[7:0], 4'h1, 1'b0, 3'(g)});
            repeat (3) @(posedge clk_i);
            chk(32'(pin_out_o[gb(1, g) +: 8]), 32'(d[7:0]));
        end
        apb(1, A_GRP, {8'h00, 8'hFF, 8'hA5, 8'h02});
        repeat (3) @(posedge clk_i);
        chk(32'(pin_out_o[gb(1, 0) +: 8]), 32'(d0[7:0]));
        apb(0, 8'h20, 0);
        chk(32'(er), 1);
        apb(0, 8'h42, 0);
        chk(32'(er), 1);
        $display("test lines done");
        // Word 0 of the lines (lines 0 to 31) is handed to the user port.
        usr_dout_i[31:0] <= $random(seed);
        usr_doe_i[31:0] <= 32'hFFFF_FFFF;
        ext[95:64] <= $random(seed);
        apb(1, {R_ARB, 4'h0}, 32'hFFFF_FFFF);
        repeat (6) @(posedge clk_i);
        chk(pin_out_o[31:0], usr_dout_i[31:0]);
        apb(0, {R_DIN, 4'h8}, 0);
        chk(rd, ext[95:64]);
        $display("test arbitration done");
        for (int m = 0; m < 5; m++) begin
            ext[70] <= (m == 1 || m == 4);
            repeat (8) @(posedge clk_i);
            wt(m, -1);
            repeat (6) @(posedge clk_i);
            apb(0, A_WCTRL, 0);
            chk(32'(rd[F_DONE]), 0);
            ext[70] <= !(m == 1 || m == 4);
            pl();
            chk(32'(rd[F_HIT:F_DONE]), 1);
        end
        wt(DLW_LOW, -1);
        pl();
        chk(32'(rd[F_HIT:F_DONE]), 1);
        wt(DLW_RISE, 0);
        pl();
        chk(32'(rd[F_HIT:F_DONE]), 3);
        apb(1, A_WCTRL, {17'h0, 7'd70, 4'h0, 3'd5, 1'b1});
        apb(0, A_WCTRL, 0);
        chk(32'(rd[F_HIT:F_BUSY]), 6);
        chk(32'(rd[F_MODE +: 3]), DLW_RISE);
        wt(DLW_RISE, 40);
        apb(0, A_WCTRL, 0);
        chk(32'(rd[F_BUSY]), 1);
        chk(32'(rd[F_SEL +: SEL_W]), 70);
        pl();
        chk(32'(rd[F_HIT:F_DONE]), 3);
        $display("test waits done");
        ext[POS_STAR] <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk(32'(usr_din_o[POS_STAR]), 1);
        slot2_i <= 1'b1;
        repeat (40) @(posedge clk_i);
        apb(0, A_STAT, 0);
        chk(rd[1:0], 3);
        chk(32'(ref_locked_o), 1);
        chk(32'({pin_oe_o[POS_STAR], usr_din_o[POS_STAR]}), 0);
        $display("test chassis done");
        give_verdict();
    end
endmodule: dlw_top_tb_top
